// *** hdl/asrr_spi.sv ***
// serial register port: direction bit, address, 16 data bits, msb first
// assumes sclk well below sys_clk/4; all pins are synchronised here
`timescale 1ns/100ps
module asrr_spi (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// serial pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	// register side
	asrr_reg_if.spi rif
);
	import asrr_pkg::*;

	typedef struct packed {
		logic [1:0] sck;
		logic [1:0] cs;
		logic [1:0] mo;
		logic sck_p;
		logic [CNT_W-1:0] bits;
		logic [SPI_FRAME_BITS-1:0] sh;
		logic [REG_W-1:0] out;
		logic [SPI_ADDR_W-1:0] addr;
		logic rw;
		logic load;
		logic wr;
		logic miso;
	} asrr_spi_t;

	// select synchroniser starts at the idle (deselected) level, so no frame opens on reset
	localparam asrr_spi_t SPI_RST = '{miso: MISO_IDLE, cs: 2'h3, default: '0};

	asrr_spi_t q;
	asrr_spi_t d;
	logic rise;
	logic fall;
	logic sel;

	// edges seen on the second synchroniser stage only
	assign rise = q.sck[1] & ~q.sck_p;
	assign fall = ~q.sck[1] & q.sck_p;
	assign sel = ~q.cs[1];

	// frame decoding; a write lands one cycle after the last data bit
	always_comb begin
		d = q;
		d.sck = {q.sck[0], spi_sclk};
		d.cs = {q.cs[0], spi_cs_n};
		d.mo = {q.mo[0], spi_mosi};
		d.sck_p = q.sck[1];
		d.wr = 1'b0;
		d.load = 1'b0;
		if (!sel) begin
			d.bits = '0;
			d.miso = MISO_IDLE;
		end else if (rise && q.bits < CNT_W'(SPI_FRAME_BITS)) begin
			d.sh = {q.sh[SPI_FRAME_BITS-2:0], q.mo[1]};
			d.bits = q.bits + 1'b1;
			if (q.bits == CNT_W'(SPI_HDR_BITS - 1)) begin
				d.rw = q.sh[SPI_ADDR_W-1];
				d.addr = {q.sh[SPI_ADDR_W-2:0], q.mo[1]};
				d.load = ~q.sh[SPI_ADDR_W-1]; // low direction bit means read
			end
			if (q.bits == CNT_W'(SPI_FRAME_BITS - 1) && q.rw) begin
				d.wr = 1'b1;
			end
		end else if (fall && !q.rw && q.bits >= CNT_W'(SPI_HDR_BITS)) begin
			d.miso = q.out[REG_W-1];
			d.out = {q.out[REG_W-2:0], 1'b0};
		end
		if (q.load) begin
			d.out = rif.rdata;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= SPI_RST;
		end else begin
			q <= d;
		end
	end

	assign rif.wr_en = q.wr;
	assign rif.addr = q.addr;
	assign rif.wdata = q.sh[REG_W-1:0];
	assign spi_miso = q.miso;

endmodule : asrr_spi

// *** hdl/asrr_top.sv ***
// sync pulse handling and data-ready clock restart for a multi-channel converter
// assumes sync_pulse_pos is asynchronous to sys_clk and is synchronised here
//
// How it works
// - extension programmable from zero to fifteen cycles
// - resync bit low stops clocks during pulse
// - resync bit high keeps toggling, rephases at fall
// - pulse also resets decimation divider, data invalid
// - release restarts ready clocks after fixed delay
// - extension register adds to restart delay
// - reset returns all settings to defaults
`timescale 1ns/100ps
module asrr_top #(
	parameter int unsigned FIX_DELAY = asrr_pkg::FIX_DELAY_DEF,
	parameter int unsigned N_CHAN = asrr_pkg::N_CHAN_DEF,
	parameter int unsigned DEC_W = asrr_pkg::DEC_W_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// synchronization pulse, active high
	input wire logic sync_pulse_pos,
	// serial register port
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	// per-channel ready clocks and data qualifiers
	output logic [N_CHAN-1:0] channel_ready_clock,
	output logic decim_tick,
	output logic data_valid
);
	import asrr_pkg::*;

	typedef struct packed {
		asrr_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [1:0] div;
		logic [DEC_W-1:0] dec;
		logic [EXT_W-1:0] ext;
		logic rm;
		logic decim;
		logic sync_m;
		logic sync_s;
		logic sync_p;
		logic [N_CHAN-1:0] rdy;
		logic tick;
		logic valid;
	} asrr_core_t;

	localparam asrr_core_t CORE_RST = '{
		st: ASRR_RUN,
		ext: EXT_RST,
		rm: RM_RST,
		decim: DECIM_RST,
		default: '0
	};

	asrr_core_t q;
	asrr_core_t d;
	logic sync_fall;
	logic [CNT_W-1:0] delay_load;
	logic [REG_W-1:0] rd;

	asrr_reg_if rif ();

	// serial port front end
	asrr_spi u_spi (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.rif(rif.spi)
	);

	// release seen on the synchronised copy; restart length is fixed part plus extension
	assign sync_fall = q.sync_p & ~q.sync_s;
	assign delay_load = CNT_W'(FIX_DELAY - 1) + {1'b0, q.ext};

	// next state of the whole core
	always_comb begin
		d = q;
		d.sync_m = sync_pulse_pos;
		d.sync_s = q.sync_m;
		d.sync_p = q.sync_s;
		// register writes; software reset restores the defaults
		if (rif.wr_en) begin
			case (rif.addr)
				ADDR_CTRL: begin
					d.rm = rif.wdata[CTRL_RM_BIT];
					d.decim = rif.wdata[CTRL_DECIM_BIT];
				end
				ADDR_SYNC: d.ext = rif.wdata[EXT_W-1:0];
				ADDR_SWRST: begin
					if (rif.wdata[SWRST_BIT]) begin
						d.ext = EXT_RST;
						d.rm = RM_RST;
						d.decim = DECIM_RST;
					end
				end
				default: d.ext = q.ext;
			endcase
		end
		// restart sequencer
		case (q.st)
			ASRR_RUN: begin
				d.div = q.div + 2'h1;
				if (q.sync_s && !q.rm) begin
					d.st = ASRR_HELD;
					d.div = '0;
				end else if (sync_fall) begin
					d.st = ASRR_DELAY;
					d.div = '0;
					d.cnt = delay_load;
				end
			end
			ASRR_HELD: begin
				d.div = '0;
				if (!q.sync_s) begin
					d.st = ASRR_DELAY;
					d.cnt = delay_load;
				end
			end
			ASRR_DELAY: begin
				d.div = '0;
				if (q.cnt == '0) begin
					d.st = ASRR_RUN;
					d.div = DIV_RESTART;
				end else begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			default: d.st = ASRR_RUN;
		endcase
		// ready clocks run at a quarter of sys_clk, low while stopped
		d.rdy = (d.st == ASRR_RUN) ? {N_CHAN{d.div[1]}} : '0;
		// decimation divider, cleared by the pulse
		d.dec = q.dec + 1'b1;
		d.tick = q.decim && (q.dec == '1);
		if (q.decim && q.sync_s) begin
			d.dec = '0;
			d.tick = 1'b0;
		end
		d.valid = (d.st == ASRR_RUN) && !q.sync_s;
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	// register read mux; unlisted addresses read zero
	always_comb begin
		rd = '0;
		case (rif.addr)
			ADDR_CTRL: begin
				rd[CTRL_RM_BIT] = q.rm;
				rd[CTRL_DECIM_BIT] = q.decim;
			end
			ADDR_STATUS: rd[8:0] = {q.st, q.sync_s, q.div, q.cnt[3:0]};
			ADDR_SYNC: rd[EXT_W-1:0] = q.ext;
			default: rd = '0;
		endcase
	end

	assign rif.rdata = rd;
	assign channel_ready_clock = q.rdy;
	assign decim_tick = q.tick;
	assign data_valid = q.valid;

	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_wait_quiet;
		(q.st == ASRR_DELAY && q.rdy == '0) [*2];
	endsequence

	sequence s_restart;
		q.st == ASRR_RUN && q.rdy == '1 ##1 q.st == ASRR_RUN && q.rdy == '1;
	endsequence

	property p_ext_bound;
		q.cnt <= CNT_W'(FIX_DELAY + EXT_MAX - 1);
	endproperty
	a_ext_bound: assert property (p_ext_bound) else $error("restart count above maximum");

	property p_hold_stop;
		(q.st == ASRR_RUN && q.sync_s && !q.rm) |=> (q.st == ASRR_HELD && q.rdy == '0);
	endproperty
	a_hold_stop: assert property (p_hold_stop) else $error("clocks not stopped by pulse");

	property p_resync_toggle;
		(q.st == ASRR_RUN && q.rm && q.sync_s) |=> (q.div == 2'($past(q.div) + 2'h1));
	endproperty
	a_resync_toggle: assert property (p_resync_toggle) else $error("divider stalled in resync");

	property p_decim_clear;
		(q.decim && q.sync_s) |=> (q.dec == '0 && !q.tick && !q.valid);
	endproperty
	a_decim_clear: assert property (p_decim_clear) else $error("decimation not cleared");

	property p_fixed_wait;
		$rose(q.st == ASRR_DELAY) |-> s_wait_quiet;
	endproperty
	a_fixed_wait: assert property (p_fixed_wait) else $error("ready restarted too early");

	property p_ext_load;
		$rose(q.st == ASRR_DELAY) |-> (q.cnt == CNT_W'(FIX_DELAY - 1) + {1'b0, $past(q.ext)});
	endproperty
	a_ext_load: assert property (p_ext_load) else $error("restart length wrong");

	property p_reset_defaults;
		$rose(rst_n) |-> (q.ext == EXT_RST && q.rm == RM_RST && q.rdy == '0 && !q.valid);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("settings not at defaults");

	property p_restart_edge;
		// a pulse already in the synchroniser may stop the clocks again, so it is excluded
		(q.st == ASRR_DELAY && q.cnt == '0 && !q.sync_s && !q.sync_m) |=> s_restart;
	endproperty
	a_restart_edge: assert property (p_restart_edge) else $error("ready did not restart");

endmodule : asrr_top

// *** shared/asrr_pkg.sv ***
// constants and types shared by the sync and ready restart logic
// assumes a single 200 MHz system clock and an active-low asynchronous reset
package asrr_pkg;

	// register port framing: one direction bit, seven address bits, sixteen data bits
	localparam int unsigned SPI_ADDR_W = 7;
	localparam int unsigned REG_W = 16;
	localparam int unsigned SPI_HDR_BITS = 8;
	localparam int unsigned SPI_FRAME_BITS = 24;

	// register offsets
	localparam logic [SPI_ADDR_W-1:0] ADDR_CTRL = 7'h01;
	localparam logic [SPI_ADDR_W-1:0] ADDR_STATUS = 7'h02;
	localparam logic [SPI_ADDR_W-1:0] ADDR_SWRST = 7'h04;
	localparam logic [SPI_ADDR_W-1:0] ADDR_SYNC = 7'h06;

	// field positions
	localparam int unsigned CTRL_RM_BIT = 12;
	localparam int unsigned CTRL_DECIM_BIT = 13;
	localparam int unsigned SWRST_BIT = 0;
	localparam int unsigned EXT_W = 4;

	// values after reset
	localparam logic [EXT_W-1:0] EXT_RST = 4'h0;
	localparam logic RM_RST = 1'b0;
	localparam logic DECIM_RST = 1'b0;
	localparam logic MISO_IDLE = 1'b1;

	// cycle counts
	localparam int unsigned EXT_MAX = 15;
	localparam int unsigned FIX_DELAY_DEF = 2;
	localparam int unsigned CNT_W = 5;
	localparam logic [1:0] DIV_RESTART = 2'h2;

	// structure defaults
	localparam int unsigned N_CHAN_DEF = 4;
	localparam int unsigned DEC_W_DEF = 2;

	// restart sequencer states
	typedef enum logic [1:0] {ASRR_RUN, ASRR_HELD, ASRR_DELAY} asrr_state_t;

endpackage : asrr_pkg

// *** shared/asrr_reg_if.sv ***
// register access path between the serial port and the sync core
// assumes both ends sit on sys_clk
`timescale 1ns/100ps
interface asrr_reg_if;
	import asrr_pkg::*;
	logic wr_en;
	logic [SPI_ADDR_W-1:0] addr;
	logic [REG_W-1:0] wdata;
	logic [REG_W-1:0] rdata;
	modport spi (output wr_en, output addr, output wdata, input rdata);
	modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : asrr_reg_if

// *** testbench/adc_sync_ready_restart_tb.sv ***
// bench: serial register access, sync pulses, restart delay checks
// assumes asrr_top with default parameters and one 200 MHz clock
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module adc_sync_ready_restart_tb;
	import asrr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk = 1'b0;
	logic cs_n = 1'b1;
	logic mosi = 1'b0;
	logic start = 1'b0;
	logic [7:0] width = 8'h0C;
	logic miso, sync_p, tick, valid;
	logic [3:0] ready;
	logic [15:0] rd;
	logic [3:0] nr, nt;
	int n_fail = 0;
	int n_tests = 0;
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	asrr_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .sync_pulse_pos(sync_p),
		.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.channel_ready_clock(ready), .decim_tick(tick), .data_valid(valid));
	asrr_sync_host host (.sys_clk(sys_clk), .rst_n(rst_n), .start(start),
		.width(width), .sync_pulse_pos(sync_p));
	// closing report
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// count ready highs and decimation ticks over eight cycles
	task watch(output logic [3:0] cr, output logic [3:0] ct);
		cr = 4'h0;
		ct = 4'h0;
		repeat (8) begin
			@(negedge sys_clk);
			cr += 4'(ready[0]);
			ct += 4'(tick);
		end
	endtask : watch
	// one 24-bit frame, msb first; miso sampled late in the low phase of each of the 16 data bits
	task xfer(input logic wr, input logic [6:0] a, input logic [15:0] wd,
		output logic [15:0] q);
		logic [23:0] f;
		f = {wr, a, wd};
		q = 16'h0000;
		cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			mosi <= f[i];
			sclk <= 1'b0;
			cyc(5);
			@(negedge sys_clk);
			if (i <= 15) q = {q[14:0], miso};
			@(posedge sys_clk);
			sclk <= 1'b1;
			cyc(6);
		end
		// last fall of sclk only after chip select is back high
		cs_n <= 1'b1;
		cyc(3);
		sclk <= 1'b0;
		cyc(10);
	endtask : xfer
	// program mode and extension, pulse sync, check hold and restart delay
	task run(input logic [15:0] ctrl, input logic [3:0] ext);
		int n;
		logic hi, vl, tk;
		xfer(1'b1, ADDR_CTRL, ctrl, rd);
		xfer(1'b1, ADDR_SYNC, {12'h000, ext}, rd);
		start <= 1'b1;
		cyc(1);
		start <= 1'b0;
		hi = 1'b0;
		vl = 1'b0;
		tk = 1'b0;
		for (n = 0; n < 40; n++) begin
			@(negedge sys_clk);
			if (n > 1 && !sync_p) break;
			if (n > 5) begin
				hi |= ready[0];
				vl |= valid;
				tk |= tick;
			end
		end
		if (n == 40) begin
			n_fail++; // bound used up counts as a mismatch
			complete_run();
		end
		`CHK("held_ready", ctrl[12], hi)
		`CHK("valid_in_pulse", 1'b0, vl)
		`CHK("tick_in_pulse", 1'b0, tk & ~ctrl[12])
		for (n = 1; n < 40; n++) begin
			@(negedge sys_clk);
			if (ready[0] && n > 2) break;
		end
		if (n == 40) begin
			n_fail++; // bound used up counts as a mismatch
			complete_run();
		end
		`CHK("restart_delay", 3 + FIX_DELAY_DEF + ext, n)
		`CHK("ready_all", 4'hF, ready)
		`CHK("valid_after", 1'b1, valid)
		watch(nr, nt);
		`CHK("ready_running", 4'h4, nr)
		`CHK("decim_ticks", ctrl[CTRL_DECIM_BIT] ? 4'h2 : 4'h0, nt)
	endtask : run
	// main sequence
	initial begin
		cyc(10);
		rst_n <= 1'b1;
		cyc(4);
		xfer(1'b0, ADDR_SYNC, 16'h0000, rd);
		`CHK("ext_reset", 16'h0000, rd)
		run(16'h2000, 4'h0);
		run(16'h0000, 4'hF);
		run(16'h1000, 4'h3);
		xfer(1'b0, ADDR_SYNC, 16'h0000, rd);
		`CHK("ext_read", 16'h0003, rd)
		xfer(1'b0, 7'h7F, 16'h0000, rd);
		`CHK("unmapped", 16'h0000, rd)
		rst_n <= 1'b0;
		cyc(10);
		rst_n <= 1'b1;
		cyc(4);
		xfer(1'b0, ADDR_CTRL, 16'h0000, rd);
		`CHK("rm_after_reset", 1'b0, rd[12])
		xfer(1'b0, ADDR_SYNC, 16'h0000, rd);
		`CHK("ext_after_reset", 16'h0000, rd)
		// another setting changed with no pulse: ready clocks keep running
		xfer(1'b1, ADDR_SYNC, 16'h0007, rd);
		watch(nr, nt);
		`CHK("ready_no_pulse", 4'h4, nr)
		xfer(1'b0, ADDR_SYNC, 16'h0000, rd);
		`CHK("ext_written", 16'h0007, rd)
		// software reset restores the extension default
		xfer(1'b1, ADDR_SWRST, 16'h0001, rd);
		xfer(1'b0, ADDR_SYNC, 16'h0000, rd);
		`CHK("ext_after_swrst", 16'h0000, rd)
		complete_run();
	end
endmodule : adc_sync_ready_restart_tb

// *** testbench/asrr_sync_host.sv ***
// stand-in for the system logic that issues sync pulses
// assumes the pin is driven just after sys_clk rising edges
`timescale 1ns/100ps
module asrr_sync_host (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// request from the bench
	input wire logic start,
	input wire logic [7:0] width,
	// sync pin
	output logic sync_pulse_pos
);
	logic [7:0] cnt_q;
	// pin held high for width cycles, edges only right after a clock edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
		end else if (start) begin
			cnt_q <= width;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	assign sync_pulse_pos = (cnt_q != 8'h00);
endmodule : asrr_sync_host
